// [logic/msd_pkg.sv]
// Constants and state codes for the memory space decoder.
// Assumes an 8-bit core that issues one request per kind at a time.
package msd_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] MSD_ROM_TOP = 16'h7FFF;     // last on-chip ROM byte
  localparam logic [15:0] MSD_AUX_TOP = 16'h00FF;     // last auxiliary RAM byte
  localparam logic [7:0] MSD_DIRECT_LIMIT = 8'h80;    // first upper location
  localparam logic [7:0] MSD_BIT_BASE = 8'h20;        // bit-addressable bytes
  localparam int MSD_BANK_SHIFT = 3;                  // eight bytes a bank
  localparam logic [2:0] MSD_BIT_IDX_LSB = 3'h3;      // byte part of a bit no.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] MSD_ALE_LAST = 3'h5;         // six periods per pulse
  localparam logic [2:0] MSD_STROBE_LAST = 3'h3;      // strobe is four cycles

  // External bus cycle states
  typedef enum logic [3:0] {
    MSD_IDLE = 4'b0001,
    MSD_ADDR = 4'b0010,
    MSD_STROBE = 4'b0100,
    MSD_DONE = 4'b1000
  } msd_bus_state_t;

endpackage : msd_pkg

// [logic/msd_decoder.sv]
// Memory space decoder: routes fetches, internal data and external moves.
// Assumes a core on ref_clk; pins go through the pad ring as in/out/oe.
//
// Behaviour
// - Latch access select during reset; low fetches externally.
// - High select: low half ROM, upper half external.
// - Security bit keeps ROM unreadable from outside.
// - Secure: external code reads cannot read ROM.
// - Main RAM upper half reachable indirectly only.
// - Aux RAM indirect via pointer regs or wide pointer.
// - Internal execution aux access leaves bus pins idle.
// - Direct upper addresses select special register space.
// - Lowest 32 bytes: four banks, one active.
// - Bytes from 32 hold 128 bit locations.
// - Stack may sit anywhere in main RAM.
// - Wide moves above 255 use multiplexed bus strobes.
// - Eight-bit pointer moves stay in aux RAM.
// - External data space low 256 bytes internal.
// - ROM 32 kbytes, program space 64 kbytes.
// - Latch strobe every six periods, one skipped.
`timescale 1ns/1ps
`default_nettype none

module msd_decoder
  import msd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Straps and fuses
  input wire logic external_access_select,
  input wire logic security_bit,
  // Program fetch and code read requests
  input wire logic fetch_req,
  input wire logic code_read_instruction,
  input wire logic [15:0] fetch_addr,
  output logic fetch_rom_sel,
  output logic fetch_ext_sel,
  output logic code_read_blocked,
  // Internal data requests
  input wire logic data_req,
  input wire logic data_indirect,
  input wire logic data_use_pointer,
  input wire logic pointer_sel,
  input wire logic data_bit,
  input wire logic stack_access,
  input wire logic [7:0] data_addr,
  input wire logic [1:0] psw_bank,
  output logic main_ram_sel,
  output logic special_register_space,
  output logic [7:0] main_ram_index,
  output logic [2:0] bit_index,
  // External move requests
  input wire logic external_move_instruction,
  input wire logic xmov_wide,
  input wire logic xmov_write,
  input wire logic [15:0] wide_data_pointer,
  input wire logic [7:0] pointer_value,
  input wire logic [7:0] xmov_wdata,
  output logic aux_ram_sel,
  output logic [7:0] aux_ram_index,
  output logic xmov_busy,
  output logic xmov_done,
  output logic [7:0] xmov_rdata,
  // External bus pins
  input wire logic [7:0] low_bus_port_in,
  output logic [7:0] low_bus_port_out,
  output logic low_bus_port_oe,
  output logic [7:0] high_address_port,
  output logic write_strobe_pin_n,
  output logic read_strobe_pin_n,
  output logic addr_latch_strobe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ea_sync_reg;
  logic [7:0] bus_s1_reg, bus_s2_reg, bus_s3_reg;
  logic ea_latched_reg;
  logic pc_external_reg;

  // Three stages; first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    ea_sync_reg <= {ea_sync_reg[1:0], external_access_select};
    bus_s1_reg <= low_bus_port_in;
    bus_s2_reg <= bus_s1_reg;
    bus_s3_reg <= bus_s2_reg;
  end

  // Strap follows the pin only while reset is held, then freezes
  always_ff @(posedge ref_clk)
  begin
    if (rst && (ea_sync_reg[1] == ea_sync_reg[2]))
      ea_latched_reg <= ea_sync_reg[2];
  end

  // ----------------------------------------------------------------
  // Program space
  // ----------------------------------------------------------------
  // Whole 64k range decodes; only the low 32k can hit ROM
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fetch_rom_sel <= 1'b0;
      fetch_ext_sel <= 1'b0;
      code_read_blocked <= 1'b0;
      pc_external_reg <= 1'b0;
    end
    else
    begin
      fetch_rom_sel <= 1'b0;
      fetch_ext_sel <= 1'b0;
      code_read_blocked <= 1'b0;
      if (fetch_req && !code_read_instruction)
      begin
        // Low strap sends every fetch out
        if (ea_latched_reg && fetch_addr <= MSD_ROM_TOP)
        begin
          fetch_rom_sel <= 1'b1;
          pc_external_reg <= 1'b0;
        end
        else
        begin
          fetch_ext_sel <= 1'b1;
          pc_external_reg <= 1'b1;
        end
      end
      else if (fetch_req)
      begin
        // Code reads from outside code must not dump protected ROM
        if (ea_latched_reg && fetch_addr <= MSD_ROM_TOP)
        begin
          if (security_bit && pc_external_reg)
            code_read_blocked <= 1'b1;
          else
            fetch_rom_sel <= 1'b1;
        end
        else
          fetch_ext_sel <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal data space
  // ----------------------------------------------------------------
  // Pointer location inside the active bank
  function automatic logic [7:0] msd_ptr_loc(input logic [1:0] bank,
                                             input logic sel);
    // Bank base is bank times eight; the pointer select adds its offset
    msd_ptr_loc = (8'(bank) << MSD_BANK_SHIFT) | 8'(sel);
  endfunction : msd_ptr_loc

  // Upper half goes to special registers only for direct and bit access
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      main_ram_sel <= 1'b0;
      special_register_space <= 1'b0;
      main_ram_index <= 8'h00;
      bit_index <= 3'h0;
    end
    else
    begin
      main_ram_sel <= 1'b0;
      special_register_space <= 1'b0;
      if (data_req)
      begin
        if (stack_access)
        begin
          main_ram_sel <= 1'b1;
          main_ram_index <= data_addr;
        end
        else if (data_use_pointer)
        begin
          main_ram_sel <= 1'b1;
          main_ram_index <= msd_ptr_loc(psw_bank, pointer_sel);
        end
        else if (data_bit && data_addr < MSD_DIRECT_LIMIT)
        begin
          main_ram_sel <= 1'b1;
          main_ram_index <= MSD_BIT_BASE +
                            8'(data_addr >> MSD_BIT_IDX_LSB);
          bit_index <= data_addr[2:0];
        end
        else if (data_indirect || data_addr < MSD_DIRECT_LIMIT)
        begin
          main_ram_sel <= 1'b1;
          main_ram_index <= data_addr;
          bit_index <= 3'h0;
        end
        else
        begin
          special_register_space <= 1'b1;
          main_ram_index <= data_addr;
          bit_index <= data_addr[2:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // External data space and bus cycle
  // ----------------------------------------------------------------
  msd_bus_state_t state_reg;
  logic [2:0] strobe_cnt_reg;
  logic [2:0] ale_cnt_reg;
  logic skip_ale_reg;
  logic go_external;

  // Only the wide form may leave the chip, and only above 255
  assign go_external = external_move_instruction && xmov_wide &&
                       wide_data_pointer > MSD_AUX_TOP;

  // Aux hits never touch the pins, whichever code space runs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aux_ram_sel <= 1'b0;
      aux_ram_index <= 8'h00;
    end
    else
    begin
      aux_ram_sel <= 1'b0;
      if (external_move_instruction && !go_external && state_reg == MSD_IDLE)
      begin
        aux_ram_sel <= 1'b1;
        aux_ram_index <= xmov_wide ? wide_data_pointer[7:0] : pointer_value;
      end
    end
  end

  // Bus cycle: address with latch pulse, then a four-cycle strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= MSD_IDLE;
      strobe_cnt_reg <= 3'h0;
      xmov_busy <= 1'b0;
      xmov_done <= 1'b0;
      xmov_rdata <= 8'h00;
      low_bus_port_out <= 8'h00;
      low_bus_port_oe <= 1'b0;
      high_address_port <= 8'h00;
      write_strobe_pin_n <= 1'b1;
      read_strobe_pin_n <= 1'b1;
    end
    else
    begin
      xmov_done <= 1'b0;
      case (state_reg)
        MSD_IDLE:
        begin
          if (go_external)
          begin
            state_reg <= MSD_ADDR;
            xmov_busy <= 1'b1;
            low_bus_port_out <= wide_data_pointer[7:0];
            low_bus_port_oe <= 1'b1;
            high_address_port <= wide_data_pointer[15:8];
          end
        end
        MSD_ADDR:
        begin
          state_reg <= MSD_STROBE;
          strobe_cnt_reg <= 3'h0;
          low_bus_port_out <= xmov_wdata;
          low_bus_port_oe <= xmov_write;
          write_strobe_pin_n <= !xmov_write;
          read_strobe_pin_n <= xmov_write;
        end
        MSD_STROBE:
        begin
          strobe_cnt_reg <= strobe_cnt_reg + 3'h1;
          if (strobe_cnt_reg == MSD_STROBE_LAST)
          begin
            state_reg <= MSD_DONE;
            // Data sampled late so three sync stages have settled
            if (!xmov_write && bus_s2_reg == bus_s3_reg)
              xmov_rdata <= bus_s3_reg;
            write_strobe_pin_n <= 1'b1;
            read_strobe_pin_n <= 1'b1;
          end
        end
        MSD_DONE:
        begin
          state_reg <= MSD_IDLE;
          low_bus_port_oe <= 1'b0;
          xmov_busy <= 1'b0;
          xmov_done <= 1'b1;
        end
        default:
          state_reg <= MSD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address latch strobe
  // ----------------------------------------------------------------
  // Free-running six-period cadence; the bus cycle's own pulse replaces
  // the regular one, so one regular pulse is dropped per access
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ale_cnt_reg <= 3'h0;
      skip_ale_reg <= 1'b0;
      addr_latch_strobe <= 1'b0;
    end
    else
    begin
      ale_cnt_reg <= (ale_cnt_reg == MSD_ALE_LAST) ? 3'h0
                                                   : ale_cnt_reg + 3'h1;
      if (state_reg == MSD_IDLE && go_external)
      begin
        skip_ale_reg <= 1'b1;
        addr_latch_strobe <= 1'b1; // address phase pulse
      end
      else if (ale_cnt_reg == MSD_ALE_LAST)
      begin
        addr_latch_strobe <= !skip_ale_reg;
        skip_ale_reg <= 1'b0;
      end
      else
        addr_latch_strobe <= 1'b0;
    end
  end

endmodule : msd_decoder

`default_nettype wire

// [tb/msd_checker.sv]
// Port checker for the memory space decoder, bound to its top module.
// Assumes the strap is held steady for the whole of each reset.
`timescale 1ns/1ps
`default_nettype none
module msd_checker
  import msd_pkg::*;
(
  // Single-bit ports
  input wire logic ref_clk, rst, external_access_select, security_bit,
  fetch_req, code_read_instruction, fetch_rom_sel, fetch_ext_sel,
  code_read_blocked, data_req, data_indirect, data_use_pointer,
  pointer_sel, data_bit, stack_access, main_ram_sel,
  special_register_space, external_move_instruction, xmov_wide,
  xmov_busy, xmov_done, aux_ram_sel, low_bus_port_oe,
  write_strobe_pin_n, read_strobe_pin_n, addr_latch_strobe,
  // Vectors
  input wire logic [15:0] fetch_addr, wide_data_pointer,
  input wire logic [7:0] data_addr, main_ram_index, high_address_port,
  input wire logic [2:0] bit_index,
  input wire logic [1:0] psw_bank
);
  logic strap_reg;
  logic [7:0] addr_reg;
  logic [15:0] dp_reg;
  logic plain_fetch, direct_req, xm_go;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Strap copy taken only in reset, so later pin changes are ignored
  always_ff @(posedge ref_clk)
    if (rst)
      strap_reg <= external_access_select;
  // Request fields one cycle back, for the registered answers
  always_ff @(posedge ref_clk)
  begin
    addr_reg <= data_addr;
    dp_reg <= wide_data_pointer;
  end
  // Request kinds
  assign plain_fetch = fetch_req && !code_read_instruction;
  assign direct_req = data_req && !data_indirect && !data_use_pointer &&
    !data_bit && !stack_access;
  assign xm_go = external_move_instruction && !xmov_busy;
  sequence s_ext_take;
    xm_go && xmov_wide && wide_data_pointer[15:8] != 8'h00;
  endsequence
  sequence s_addr_out;
    xmov_busy && addr_latch_strobe && low_bus_port_oe &&
    high_address_port == dp_reg[15:8];
  endsequence
  a_rom_fetch_route: assert property (
    plain_fetch && strap_reg && !fetch_addr[15] |=>
    fetch_rom_sel && !fetch_ext_sel) else $error("rom fetch misrouted");
  a_ext_fetch_route: assert property (
    plain_fetch && !(strap_reg && !fetch_addr[15]) |=>
    fetch_ext_sel && !fetch_rom_sel) else $error("ext fetch misrouted");
  a_open_code_read: assert property (
    fetch_req && code_read_instruction && !security_bit |=>
    !code_read_blocked) else $error("open code read blocked");
  a_upper_direct: assert property (
    direct_req && data_addr[7] |=> special_register_space &&
    !main_ram_sel) else $error("upper direct not special");
  a_indirect_main: assert property (
    data_req && data_indirect && !data_use_pointer && !data_bit |=>
    main_ram_sel && main_ram_index == addr_reg)
    else $error("indirect main access wrong");
  a_bank_pointer: assert property (
    data_req && data_use_pointer |=> main_ram_index ==
    {3'h0, $past(psw_bank), 2'h0, $past(pointer_sel)})
    else $error("bank pointer location wrong");
  a_bit_byte: assert property (
    data_req && data_bit && !data_addr[7] |=> main_ram_index ==
    {4'h2, addr_reg[6:3]} && bit_index == addr_reg[2:0])
    else $error("bit location wrong");
  a_aux_quiet: assert property (
    xm_go && (!xmov_wide || wide_data_pointer[15:8] == 8'h00) |=>
    aux_ram_sel && !low_bus_port_oe && read_strobe_pin_n &&
    write_strobe_pin_n && !xmov_busy) else $error("aux access on bus");
  a_ext_cycle: assert property (
    s_ext_take |=> s_addr_out ##6 xmov_done)
    else $error("external cycle shape wrong");
  a_read_width: assert property (
    $fell(read_strobe_pin_n) |-> !read_strobe_pin_n[*4] ##1
    read_strobe_pin_n) else $error("read strobe width wrong");
endmodule : msd_checker
bind msd_decoder msd_checker chk_u (.*);
`default_nettype wire

// [tb/msd_ext_mem.sv]
// External data memory model on the multiplexed port bus.
// Assumes address latched on the strobe while the decoder drives.
`timescale 1ns/1ps
`default_nettype none
module msd_ext_mem
(
  // Bus from the decoder
  input wire logic ref_clk, low_bus_port_oe, addr_latch_strobe,
  input wire logic write_strobe_pin_n, read_strobe_pin_n,
  input wire logic [7:0] low_bus_port_out, high_address_port,
  // Data back to the decoder
  output logic [7:0] low_bus_port_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_reg;
  logic [7:0] last_reg = 8'h5A;
  // High byte on its own port, low byte muxed with data
  always_ff @(posedge ref_clk)
  begin
    if (addr_latch_strobe && low_bus_port_oe)
      addr_reg <= {high_address_port, low_bus_port_out};
    if (!write_strobe_pin_n)
      mem[addr_reg] <= low_bus_port_out;
    if (!read_strobe_pin_n)
      last_reg <= mem[addr_reg];
  end
  // Released bus shows the inverse, so a stale byte cannot pass
  assign low_bus_port_in = read_strobe_pin_n ? ~last_reg : mem[addr_reg];
endmodule : msd_ext_mem
`default_nettype wire

// [tb/msd_tb.sv]
// Self-checking bench for the memory space decoder.
// Assumes the decoder, its bound checker and the memory model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import msd_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, external_access_select = 1'b1;
  logic security_bit = 1'b1, fetch_req = 1'b0, code_read_instruction = 1'b0;
  logic data_req = 1'b0, data_indirect = 1'b0, data_use_pointer = 1'b0;
  logic pointer_sel = 1'b0, data_bit = 1'b0, stack_access = 1'b0;
  logic external_move_instruction = 1'b0, xmov_wide = 1'b0, xmov_write = 1'b0;
  logic [15:0] fetch_addr = 16'h0000, wide_data_pointer = 16'h0000;
  logic [7:0] data_addr = 8'h00, pointer_value = 8'h00, xmov_wdata = 8'h00;
  logic [1:0] psw_bank = 2'h0;
  logic fetch_rom_sel, fetch_ext_sel, code_read_blocked, main_ram_sel;
  logic special_register_space, aux_ram_sel, xmov_busy, xmov_done;
  logic low_bus_port_oe, write_strobe_pin_n, read_strobe_pin_n;
  logic addr_latch_strobe;
  logic [7:0] main_ram_index, aux_ram_index, xmov_rdata, low_bus_port_in;
  logic [7:0] low_bus_port_out, high_address_port;
  logic [2:0] bit_index;
  int n_mismatch = 0, checks_done = 0;
  msd_decoder dut_u (.*);
  msd_ext_mem mem_u (.*);
  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Four edges so the strap passes the synchroniser
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst <= 1'b1;
    external_access_select <= s;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset
  // Code reads only judge the ROM select and the block flag
  task automatic fetch(input logic [15:0] a, input logic c,
    input logic [2:0] e);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    code_read_instruction <= c;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    #1;
    if (c)
      chk({fetch_rom_sel, code_read_blocked}, {e[2], e[0]});
    else
      chk({fetch_rom_sel, fetch_ext_sel, code_read_blocked}, e);
  endtask : fetch
  // Mode is {indirect, pointer, pointer select, bit, stack}
  task automatic dat(input logic [4:0] m, input logic [7:0] a,
    input logic [1:0] b, input logic [12:0] e);
    @(posedge ref_clk);
    {data_indirect, data_use_pointer, pointer_sel, data_bit,
      stack_access} <= m;
    data_addr <= a;
    psw_bank <= b;
    data_req <= 1'b1;
    @(posedge ref_clk);
    data_req <= 1'b0;
    #1;
    chk({main_ram_sel, special_register_space}, e[12:11]);
    if (e[12])
      chk(main_ram_index, e[10:3]);
    if (m[1])
      chk(bit_index, e[2:0]);
  endtask : dat
  // One external move; request pulsed for one cycle, other inputs held until the cycle completes
  task automatic xm(input logic w, input logic wr, input logic [15:0] dp,
    input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    external_move_instruction <= 1'b1;
    xmov_wide <= w;
    xmov_write <= wr;
    wide_data_pointer <= dp;
    pointer_value <= dp[7:0];
    xmov_wdata <= d;
    @(posedge ref_clk);
    external_move_instruction <= 1'b0;
    #1;
    if (!w || dp[15:8] == 8'h00)
      chk({aux_ram_sel, aux_ram_index, low_bus_port_oe},
        {1'h1, dp[7:0], 1'h0});
    else
    begin
      chk({xmov_busy, high_address_port, low_bus_port_out}, {1'h1, dp});
      for (i = 0; i < 20 && xmov_done !== 1'b1; i++)
      begin
        @(posedge ref_clk);
        #1;
      end
      chk(16'(i), 16'h0006);
      if (!wr)
        chk(xmov_rdata, d);
    end
  endtask : xm
  // Idle address strobe cadence, one pulse per six cycles
  task automatic ale_count();
    int n;
    n = 0;
    repeat (24)
    begin
      @(posedge ref_clk);
      #1;
      n += int'(addr_latch_strobe);
    end
    chk(16'(n), 16'h0004);
  endtask : ale_count
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Whole run needs about a hundred cycles
  initial
  begin
    #(8 * 3000);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    do_reset(1'h1);
    fetch(16'h7FFF, 1'h0, 3'h4);
    fetch(16'h8000, 1'h0, 3'h2);
    fetch(16'h0100, 1'h1, 3'h1);
    fetch(16'h0000, 1'h0, 3'h4);
    fetch(16'h0100, 1'h1, 3'h4);
    @(posedge ref_clk) security_bit <= 1'b0;
    fetch(16'hFFFF, 1'h0, 3'h2);
    fetch(16'h0100, 1'h1, 3'h4);
    @(posedge ref_clk) external_access_select <= 1'b0;
    fetch(16'h0000, 1'h0, 3'h4);
    do_reset(1'h0);
    fetch(16'h0000, 1'h0, 3'h2);
    fetch(16'h7FFF, 1'h0, 3'h2);
    dat(5'h00, 8'h7F, 2'h0, {2'h2, 8'h7F, 3'h0});
    dat(5'h00, 8'h80, 2'h0, {2'h1, 8'h00, 3'h0});
    dat(5'h10, 8'h80, 2'h0, {2'h2, 8'h80, 3'h0});
    dat(5'h0C, 8'h00, 2'h2, {2'h2, 8'h11, 3'h0});
    dat(5'h08, 8'h00, 2'h3, {2'h2, 8'h18, 3'h0});
    dat(5'h02, 8'h7F, 2'h0, {2'h2, 8'h2F, 3'h7});
    dat(5'h02, 8'h0A, 2'h1, {2'h2, 8'h21, 3'h2});
    dat(5'h01, 8'hFF, 2'h0, {2'h2, 8'hFF, 3'h0});
    xm(1'h0, 1'h1, 16'h12C3, 8'h00);
    xm(1'h1, 1'h0, 16'h00FF, 8'h00);
    xm(1'h1, 1'h1, 16'h0100, 8'hA5);
    xm(1'h1, 1'h0, 16'h0100, 8'hA5);
    ale_count();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
